// ### bench/pfps_prog_model.sv
// Parallel device programmer model: drives ports 0 to 3 and the
// address-latch strobe of the programming bus.
// Assumes the device drives port 0 back only while p0_oe is high.
`timescale 1ns/1ps
`default_nettype none
module pfps_prog_model import pfps_pkg::*; (
	input wire logic clk,
	input wire logic [7:0] p0_out,
	input wire logic p0_oe,
	output var pfps_par_s par
);
	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	logic [7:0] p0_q = 8'h00;
	logic [7:0] p1_q = 8'h00;
	logic [7:0] p2_q = 8'h00;
	logic [7:0] p3_q = 8'h0e;
	logic ale_q = 1'b0;
	logic hold_q = 1'b1;
	logic [7:0] p0_w;

	// Port 0 level from both enables; a released bus shows the inverse of its last byte
	assign p0_w = p0_oe ? p0_out : (hold_q ? p0_q : ~p0_q);
	assign par = '{p0: p0_w, p1: p1_q, p2: p2_q, p3: p3_q, ale: ale_q};

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// One programming write: bus set up first, then a single strobe pulse
	task automatic wr(input logic [7:0] mode, input logic [12:0] addr, input logic [7:0] data);
		@(posedge clk);
		p3_q <= mode;
		p2_q <= {3'h0, addr[12:8]};
		p1_q <= addr[7:0];
		p0_q <= data;
		hold_q <= 1'b1;
		@(posedge clk);
		ale_q <= 1'b1;
		@(posedge clk);
		ale_q <= 1'b0;
		@(posedge clk);
	endtask

	// Readback: release port 0, hold the mode and take the device's byte
	task automatic rd(input logic [7:0] mode, input logic [12:0] addr, output logic [7:0] data,
		output logic oe);
		@(posedge clk);
		p3_q <= mode;
		p2_q <= {3'h0, addr[12:8]};
		p1_q <= addr[7:0];
		hold_q <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		data = p0_w;
		oe = p0_oe;
	endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the programming and security block.
// Assumes the programmer model beside it and one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top import pfps_pkg::*;;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic nv_init = 1'b1;
	logic download_strap_n = 1'b1;
	logic prog_mode = 1'b0;
	pfps_par_s par;
	logic [7:0] p0_out;
	logic p0_oe;
	logic ser_we = 1'b0;
	logic ser_erase = 1'b0;
	logic [12:0] ser_addr = 13'h0;
	logic [7:0] ser_data = 8'h00;
	logic code_rd = 1'b0;
	logic code_from_ext = 1'b0;
	logic [15:0] code_addr = 16'h0;
	logic [7:0] code_rdata;
	logic code_denied;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic dl_mode;
	pfps_sec_s sec_active;
	logic busy;
	int fail_count = 0;
	int check_count = 0;
	logic [7:0] d;
	logic f;

	pfps_ctrl u_dut (.clk, .reset, .nv_init, .download_strap_n, .prog_mode, .par, .p0_out, .p0_oe,
		.ser_we, .ser_erase, .ser_addr, .ser_data, .code_rd, .code_from_ext, .code_addr, .code_rdata,
		.code_denied, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dl_mode, .sec_active, .busy);
	pfps_prog_model u_prog (.clk, .p0_out, .p0_oe, .par);

	// Clock at 200 MHz
	initial begin
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic do_reset(input logic strap_n);
		@(posedge clk);
		reset <= 1'b1;
		download_strap_n <= strap_n;
		@(posedge clk);
		@(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic set_pm(input logic v);
		@(posedge clk);
		prog_mode <= v;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic code_read(input logic [15:0] a, input logic ext, output logic [7:0] v, output logic den);
		@(posedge clk);
		code_addr <= a;
		code_from_ext <= ext;
		code_rd <= 1'b1;
		@(posedge clk);
		code_rd <= 1'b0;
		#1;
		v = code_rdata;
		den = code_denied;
	endtask

	// Serial download pulse: write byte or code erase
	task automatic ser_op(input logic er, input logic [12:0] a, input logic [7:0] v);
		@(posedge clk);
		ser_addr <= a;
		ser_data <= v;
		ser_we <= ~er;
		ser_erase <= er;
		@(posedge clk);
		ser_we <= 1'b0;
		ser_erase <= 1'b0;
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		// Let the launching edge settle before busy is looked at
		#1;
		while (busy !== 1'b0 && n < 20000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 20000) begin
			fail_count++;
			$display("mismatch busy expected 0 seen 1");
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog well beyond the longest run of erase sweeps
	initial begin
		#400000;
		fail_count++;
		$display("mismatch watchdog expected done seen timeout");
		wrap_up();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		@(posedge clk);
		nv_init <= 1'b0;
		@(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("sec_active", 3'h0, sec_active)
		`CHK("dl_mode", 1'b0, dl_mode)
		$display("test power_up done");
		// Full erase with upper port 3 bits set
		set_pm(1'b1);
		u_prog.wr(8'hf0, 13'h0, 8'h00);
		`CHK("busy", 1'b1, busy)
		wait_idle();
		u_prog.rd(8'h16, 13'h1fff, d, f);
		`CHK("code_ff", 8'hff, d)
		`CHK("p0_oe", 1'b1, f)
		u_prog.rd(8'h06, 13'h27f, d, f);
		`CHK("data_ff", 8'hff, d)
		$display("test erase done");
		// Mode codes: program, reprogram, signature, data byte, unused code
		u_prog.wr(8'h14, 13'h1fff, 8'ha5);
		u_prog.rd(8'h16, 13'h1fff, d, f);
		`CHK("code_byte", 8'ha5, d)
		u_prog.wr(8'h14, 13'h1fff, 8'h00);
		u_prog.rd(8'h16, 13'h1fff, d, f);
		`CHK("code_reprog", 8'ha5, d)
		u_prog.rd(8'h02, 13'h0, d, f);
		`CHK("signature", SIG_VALUE, d)
		u_prog.wr(8'h04, 13'h27f, 8'h3c);
		u_prog.rd(8'h06, 13'h27f, d, f);
		`CHK("data_byte", 8'h3c, d)
		u_prog.wr(8'h1e, 13'h1ffe, 8'h00);
		u_prog.rd(8'h16, 13'h1ffe, d, f);
		`CHK("unused_code", 8'hff, d)
		code_read(16'h1fff, 1'b0, d, f);
		`CHK("core_top", 8'ha5, d)
		code_read(16'h2000, 1'b0, d, f);
		`CHK("core_beyond", 8'hff, d)
		$display("test parallel done");
		// Data flash through the peripheral registers
		set_pm(1'b0);
		reg_write(REG_PAGE, 8'h03);
		for (int i = 0; i < 4; i++) begin
			reg_write(REG_DATA1 + 8'(i), 8'h11 * 8'(i + 1));
		end
		reg_write(REG_CTRL, CMD_PROG);
		reg_write(REG_DATA1 + 8'h1, 8'h00);
		reg_write(REG_CTRL, CMD_READ);
		reg_read(REG_DATA1 + 8'h1, d);
		`CHK("page_byte1", 8'h22, d)
		reg_write(REG_DATA1 + 8'h1, 8'h00);
		reg_write(REG_CTRL, CMD_VERIFY);
		reg_read(REG_CTRL, d);
		`CHK("verify", VERIFY_BAD, d)
		reg_write(REG_CTRL, CMD_ERASE);
		reg_write(REG_CTRL, CMD_READ);
		reg_read(REG_DATA1, d);
		`CHK("page_erase", 8'hff, d)
		reg_write(REG_PAGE, 8'h9f);
		reg_write(REG_CTRL, CMD_READ);
		reg_read(REG_DATA4, d);
		`CHK("par_data_view", 8'h3c, d)
		reg_read(8'h00, d);
		`CHK("unmapped", 8'h00, d)
		reg_write(REG_CTRL, CMD_ERASE_ALL);
		wait_idle();
		reg_write(REG_CTRL, CMD_READ);
		reg_read(REG_DATA4, d);
		`CHK("erase_all", 8'hff, d)
		$display("test data_flash done");
		// Lock mode
		set_pm(1'b1);
		u_prog.wr(8'h08, 13'h0, 8'h01);
		u_prog.rd(8'h0a, 13'h0, d, f);
		`CHK("sec_cells", 8'h01, d)
		`CHK("sec_before_reset", 3'h0, sec_active)
		do_reset(1'b1);
		`CHK("sec_lock", 3'h1, sec_active)
		u_prog.wr(8'h14, 13'h0, 8'h55);
		u_prog.rd(8'h16, 13'h0, d, f);
		`CHK("lock_prog", 8'hff, d)
		u_prog.rd(8'h16, 13'h1fff, d, f);
		`CHK("lock_read", 8'ha5, d)
		// Secure mode added independently
		u_prog.wr(8'h08, 13'h0, 8'h02);
		do_reset(1'b1);
		`CHK("sec_secure", 3'h3, sec_active)
		u_prog.rd(8'h16, 13'h1fff, d, f);
		`CHK("secure_read", 8'hff, d)
		code_read(16'h1fff, 1'b1, d, f);
		`CHK("ext_denied", 1'b1, f)
		code_read(16'h1fff, 1'b0, d, f);
		`CHK("int_read", 8'ha5, d)
		`CHK("int_denied", 1'b0, f)
		$display("test lock_secure done");
		// Serial download, serial erase, serial safe
		set_pm(1'b0);
		do_reset(1'b0);
		`CHK("dl_entry", 1'b1, dl_mode)
		ser_op(1'b0, 13'h0, 8'h77);
		code_read(16'h0000, 1'b0, d, f);
		`CHK("ser_write", 8'h77, d)
		ser_op(1'b1, 13'h0, 8'h00);
		wait_idle();
		do_reset(1'b0);
		`CHK("ser_clear", 3'h0, sec_active)
		code_read(16'h1fff, 1'b0, d, f);
		`CHK("ser_erased", 8'hff, d)
		set_pm(1'b1);
		u_prog.wr(8'h08, 13'h0, 8'h04);
		set_pm(1'b0);
		ser_op(1'b1, 13'h0, 8'h00);
		wait_idle();
		do_reset(1'b0);
		`CHK("safe_kept", 3'h4, sec_active)
		`CHK("safe_no_dl", 1'b0, dl_mode)
		set_pm(1'b1);
		u_prog.wr(8'hf0, 13'h0, 8'h00);
		wait_idle();
		do_reset(1'b0);
		`CHK("par_clear", 3'h0, sec_active)
		`CHK("dl_again", 1'b1, dl_mode)
		$display("test serial done");
		wrap_up();
	end
endmodule
`default_nettype wire

// ### rtl/pfps_ctrl.sv
// Program flash programming entry and security: parallel programming
// decode, serial download entry, security modes, code array and the
// data flash peripheral registers.
// Assumes inputs synchronous to clk and security cells cleared by nv_init.
//
// Operation
// - Code array fills the lowest 8 Kbytes of the 64 Kbyte code space.
// - Strap low at reset enters serial download over the UART.
// - Ports 0, 1, 2 carry programming address and data.
// - Address-latch pin is the write strobe for each programming access.
// - Port 3 mode code selects program, read or erase.
// - Port 3 bits 3..1 zero erase code, data and security.
// - Codes: signature, program, read, security program, security read.
// - Three security modes, each set independently.
// - Lock blocks parallel code program, keeps reads; code-erase clears it.
// - Secure blocks parallel code program, code read and external code reads.
// - Serial safe turns a strap-low reset into a normal reset.
// - Serial safe clears only by parallel erase, never serial.
// - Data flash via six registers, byte program, page erase.
// - Program only erased bytes; erase writes all ones.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pfps_ctrl import pfps_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic nv_init,
	input wire logic download_strap_n,
	input wire logic prog_mode,
	input wire pfps_par_s par,
	output logic [7:0] p0_out,
	output logic p0_oe,
	input wire logic ser_we,
	input wire logic ser_erase,
	input wire logic [12:0] ser_addr,
	input wire logic [7:0] ser_data,
	input wire logic code_rd,
	input wire logic code_from_ext,
	input wire logic [15:0] code_addr,
	output logic [7:0] code_rdata,
	output logic code_denied,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic dl_mode,
	output pfps_sec_s sec_active,
	output logic busy
);
	typedef enum logic {PFPS_IDLE, PFPS_ERASE} pfps_state_e;

	logic [7:0] code_mem_q [0:CODE_SIZE-1];
	pfps_state_e state_q;
	logic [12:0] ers_idx_q;
	pfps_sec_s nv_q;
	pfps_sec_s act_q;
	logic dl_mode_q;
	logic ale_q;
	logic [7:0] p0_out_q;
	logic p0_oe_q;
	logic [7:0] code_rdata_q;
	logic code_denied_q;
	logic [7:0] page_q;
	logic [31:0] edata_q;
	logic [7:0] ctrl_q;
	logic [7:0] reg_rdata_q;
	logic strobe;
	logic idle;
	logic [2:0] mode;
	logic sel_code;
	logic [12:0] pa_code;
	logic [9:0] pa_data;
	logic par_erase;
	logic ser_erase_go;
	logic par_pcode;
	logic code_we;
	logic [12:0] code_wa;
	logic [7:0] code_wd;
	logic cmd_go;
	logic [7:0] dm_pg;
	logic [31:0] dm_page;
	logic dm_we;
	logic [3:0] dm_be;
	logic [31:0] dm_wd;
	logic dm_pg_erase;
	logic dm_all_erase;
	logic dm_busy;
	logic code_int;

	// ----------------------------------------
	// Parallel bus decode
	// ----------------------------------------
	// Address-latch rising edge is the programming write strobe
	assign strobe = prog_mode & par.ale & ~ale_q;
	assign idle = (state_q == PFPS_IDLE) && !dm_busy;
	assign mode = par.p3[P3_MODE_HI:P3_MODE_LO];
	assign sel_code = par.p3[P3_SEL_BIT];
	assign pa_code = {par.p2[4:0], par.p1};
	assign pa_data = {par.p2[1:0], par.p1};
	assign par_erase = strobe && idle && mode == PM_ERASE;
	assign ser_erase_go = dl_mode_q && ser_erase && idle;
	assign par_pcode = strobe && idle && mode == PM_PROG && sel_code;

	always_ff @(posedge clk) begin
		if (reset) begin
			ale_q <= 1'b0;
		end else begin
			ale_q <= par.ale;
		end
	end

	// ----------------------------------------
	// Code array writes
	// ----------------------------------------
	// Lock and secure refuse parallel code programming
	always_comb begin
		code_we = 1'b0;
		code_wa = pa_code;
		code_wd = par.p0;
		if (par_pcode) begin
			code_we = !act_q.lock && !act_q.secure && pfps_erased(code_mem_q[pa_code]);
		end else if (dl_mode_q && ser_we && idle) begin
			code_wa = ser_addr;
			code_wd = ser_data;
			code_we = pfps_erased(code_mem_q[ser_addr]);
		end
	end

	// Erase sweep fills every code byte with ones
	always_ff @(posedge clk) begin
		if (state_q == PFPS_ERASE) begin
			code_mem_q[ers_idx_q] <= ERASED;
		end else if (code_we) begin
			code_mem_q[code_wa] <= code_wd;
		end
	end

	// ----------------------------------------
	// Code erase sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= PFPS_IDLE;
			ers_idx_q <= 13'h0000;
		end else begin
			unique case (state_q)
				PFPS_IDLE: begin
					if (par_erase || ser_erase_go) begin
						state_q <= PFPS_ERASE;
						ers_idx_q <= 13'h0000;
					end
				end
				PFPS_ERASE: begin
					ers_idx_q <= ers_idx_q + 13'h0001;
					if (ers_idx_q == CODE_LAST) begin
						state_q <= PFPS_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Security modes
	// ----------------------------------------
	// Nonvolatile cells; each bit set on its own, parallel erase clears all, serial erase all but safe
	always_ff @(posedge clk) begin
		if (nv_init) begin
			nv_q <= '0;
		end else if (par_erase) begin
			nv_q <= '0;
		end else if (ser_erase_go) begin
			nv_q.lock <= 1'b0;
			nv_q.secure <= 1'b0;
		end else if (strobe && idle && mode == PM_SEC_PROG) begin
			nv_q <= nv_q | pfps_sec_s'(par.p0[SEC_W-1:0]);
		end
	end

	// Active copy loaded from the cells at every reset
	always_ff @(posedge clk) begin
		if (reset) begin
			act_q <= nv_q;
		end else if (par_erase) begin
			act_q <= '0;
		end else if (ser_erase_go) begin
			act_q.lock <= 1'b0;
			act_q.secure <= 1'b0;
		end
	end

	// Strap caught during reset unless serial safe is set
	always_ff @(posedge clk) begin
		if (reset) begin
			dl_mode_q <= !download_strap_n && !nv_q.safe;
		end
	end

	// ----------------------------------------
	// Parallel readback
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			p0_out_q <= 8'h00;
			p0_oe_q <= 1'b0;
		end else begin
			p0_oe_q <= prog_mode && (mode == PM_SIG || mode == PM_READ || mode == PM_SEC_READ);
			if (prog_mode) begin
				unique case (mode)
					PM_SIG: p0_out_q <= SIG_VALUE;
					PM_READ: begin
						if (!sel_code) begin
							p0_out_q <= dm_page[8*pa_data[1:0] +: 8];
						end else if (act_q.secure) begin
							p0_out_q <= ERASED;
						end else begin
							p0_out_q <= code_mem_q[pa_code];
						end
					end
					PM_SEC_READ: p0_out_q <= {5'h00, nv_q};
					default: p0_out_q <= p0_out_q;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Core code reads
	// ----------------------------------------
	assign code_int = code_addr < CODE_TOP;

	always_ff @(posedge clk) begin
		if (reset) begin
			code_rdata_q <= 8'h00;
			code_denied_q <= 1'b0;
		end else if (code_rd) begin
			code_denied_q <= code_from_ext && act_q.secure && code_int;
			if (code_int && !(code_from_ext && act_q.secure)) begin
				code_rdata_q <= code_mem_q[code_addr[12:0]];
			end else begin
				code_rdata_q <= ERASED;
			end
		end
	end

	// ----------------------------------------
	// Data flash routing
	// ----------------------------------------
	assign cmd_go = reg_wr && reg_addr == REG_CTRL && !prog_mode && idle;
	assign dm_pg = prog_mode ? pa_data[9:2] : page_q;

	always_comb begin
		dm_we = 1'b0;
		dm_be = 4'h0;
		dm_wd = edata_q;
		dm_pg_erase = 1'b0;
		dm_all_erase = par_erase;
		if (strobe && idle && mode == PM_PROG && !sel_code) begin
			dm_we = 1'b1;
			dm_be = 4'h1 << pa_data[1:0];
			dm_wd = {4{par.p0}};
		end else if (cmd_go) begin
			dm_we = reg_wdata == CMD_PROG;
			dm_be = 4'hf;
			dm_pg_erase = reg_wdata == CMD_ERASE;
			dm_all_erase = reg_wdata == CMD_ERASE_ALL;
		end
	end

	pfps_dmem u_dmem (
		.clk(clk),
		.reset(reset),
		.pg(dm_pg),
		.rd_page(dm_page),
		.wr_en(dm_we),
		.wr_be(dm_be),
		.wr_data(dm_wd),
		.pg_erase(dm_pg_erase),
		.all_erase(dm_all_erase),
		.busy(dm_busy)
	);

	// ----------------------------------------
	// Peripheral registers
	// ----------------------------------------
	// Page, data bytes and command with verify result
	always_ff @(posedge clk) begin
		if (reset) begin
			page_q <= 8'h00;
			edata_q <= 32'h0000_0000;
			ctrl_q <= CTRL_RESET;
		end else if (reg_wr) begin
			if (reg_addr == REG_PAGE) begin
				page_q <= reg_wdata;
			end else if (reg_addr >= REG_DATA1 && reg_addr <= REG_DATA4) begin
				edata_q[8*reg_addr[1:0] +: 8] <= reg_wdata;
			end else if (cmd_go) begin
				ctrl_q <= reg_wdata;
				if (reg_wdata == CMD_READ) begin
					edata_q <= dm_page;
				end else if (reg_wdata == CMD_VERIFY) begin
					ctrl_q <= (dm_page == edata_q) ? 8'h00 : VERIFY_BAD;
				end
			end
		end
	end

	// Read data one cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= 8'h00;
			if (reg_rd) begin
				if (reg_addr == REG_CTRL) begin
					reg_rdata_q <= ctrl_q;
				end else if (reg_addr == REG_PAGE) begin
					reg_rdata_q <= page_q;
				end else if (reg_addr >= REG_DATA1 && reg_addr <= REG_DATA4) begin
					reg_rdata_q <= edata_q[8*reg_addr[1:0] +: 8];
				end
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign p0_out = p0_out_q;
	assign p0_oe = p0_oe_q;
	assign code_rdata = code_rdata_q;
	assign code_denied = code_denied_q;
	assign reg_rdata = reg_rdata_q;
	assign dl_mode = dl_mode_q;
	assign sec_active = act_q;
	assign busy = !idle;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	AST_MAP_TOP: assert property (code_rd && !code_int |=> code_rdata == ERASED && !code_denied)
		else $error("read above code array not erased value");
	AST_DL_ENTRY: assert property (@(posedge clk) disable iff (nv_init)
		reset && !download_strap_n && !nv_q.safe ##1 !reset |-> dl_mode)
		else $error("strap low reset did not enter download");
	AST_SAFE_BLOCK: assert property (@(posedge clk) disable iff (nv_init)
		reset && nv_q.safe |=> !dl_mode)
		else $error("download entered with serial safe set");
	AST_ERASE_ALL: assert property (par_erase && !nv_init |=> nv_q == '0 && act_q == '0 && busy)
		else $error("parallel erase left security or not busy");
	AST_SIG_READ: assert property (prog_mode && mode == PM_SIG |=> p0_out == SIG_VALUE && p0_oe)
		else $error("signature read wrong");
	AST_LOCK_PROG: assert property (par_pcode && act_q.lock |-> !code_we)
		else $error("code programmed while locked");
	AST_SEC_READ: assert property (prog_mode && mode == PM_READ && sel_code && act_q.secure |=> p0_out == ERASED)
		else $error("code read while secure");
	AST_CODE_MEMORY_READ_INSTR_BLOCK: assert property (code_rd && code_from_ext && code_int && act_q.secure |=> code_denied)
		else $error("external code read not denied");
	AST_SER_SAFE: assert property (ser_erase_go && !nv_init |=> nv_q.safe == $past(nv_q.safe, 1))
		else $error("serial erase changed serial safe");
	AST_SEC_SET: assert property (!nv_init && $rose(nv_q.lock) |-> $past(strobe && mode == PM_SEC_PROG, 1))
		else $error("lock set without security program");
	AST_ERASE_LEN: assert property ($rose(state_q == PFPS_ERASE) |-> (state_q == PFPS_ERASE)[*8])
		else $error("code erase sweep ended early");

	COV_PAR_ERASE: cover property (par_erase);
	COV_DL_ENTRY: cover property (dl_mode && ser_we && code_we);
	COV_DM_PROG: cover property (cmd_go && reg_wdata == CMD_PROG);
	COV_VERIFY: cover property (cmd_go && reg_wdata == CMD_VERIFY);
endmodule
`default_nettype wire

// ### rtl/pfps_dmem.sv
// Data flash array: 160 pages of four bytes, page read, byte-masked
// program of erased bytes, page erase and whole-array erase sweep.
// Assumes the caller issues one operation at a time while not busy.
`timescale 1ns/1ps
`default_nettype none
module pfps_dmem import pfps_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] pg,
	output logic [31:0] rd_page,
	input wire logic wr_en,
	input wire logic [3:0] wr_be,
	input wire logic [31:0] wr_data,
	input wire logic pg_erase,
	input wire logic all_erase,
	output logic busy
);
	logic [7:0] mem_q [0:DATA_SIZE-1];
	logic sweep_q;
	logic [9:0] idx_q;
	logic pg_ok;

	// ----------------------------------------
	// Page decode and read
	// ----------------------------------------
	assign pg_ok = pg < DATA_PAGES;
	assign busy = sweep_q;

	// Unmapped pages read as erased
	always_comb begin
		rd_page = {4{ERASED}};
		if (pg_ok) begin
			for (int b = 0; b < 4; b++) begin
				rd_page[8*b +: 8] = mem_q[10'({pg, 2'b00}) + 10'(b)];
			end
		end
	end

	// ----------------------------------------
	// Erase-all sweep
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			sweep_q <= 1'b0;
			idx_q <= 10'h000;
		end else if (sweep_q) begin
			idx_q <= idx_q + 10'h001;
			if (idx_q == DATA_LAST) begin
				sweep_q <= 1'b0;
			end
		end else if (all_erase) begin
			sweep_q <= 1'b1;
			idx_q <= 10'h000;
		end
	end

	// ----------------------------------------
	// Array update
	// ----------------------------------------
	// Bytes accept programming only while erased
	always_ff @(posedge clk) begin
		if (sweep_q) begin
			mem_q[idx_q] <= ERASED;
		end else if (pg_erase && pg_ok) begin
			for (int b = 0; b < 4; b++) begin
				mem_q[10'({pg, 2'b00}) + 10'(b)] <= ERASED;
			end
		end else if (wr_en && pg_ok) begin
			for (int b = 0; b < 4; b++) begin
				if (wr_be[b] && pfps_erased(rd_page[8*b +: 8])) begin
					mem_q[10'({pg, 2'b00}) + 10'(b)] <= wr_data[8*b +: 8];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/pfps_pkg.sv
// Constants, field layouts and carrier types for the program flash
// programming and security block.
// Assumes one 200 MHz clock and 8-bit peripheral register port.
package pfps_pkg;
	// ----------------------------------------
	// Memory geometry
	// ----------------------------------------
	localparam int unsigned CODE_SIZE = 8192;
	localparam int unsigned CODE_SPACE = 65536;
	localparam logic [12:0] CODE_LAST = 13'h1fff;
	localparam logic [15:0] CODE_TOP = 16'h2000;
	localparam int unsigned DATA_SIZE = 640;
	localparam logic [7:0] DATA_PAGES = 8'ha0;
	localparam logic [9:0] DATA_LAST = 10'h27f;
	localparam logic [7:0] ERASED = 8'hff;
	// Signature byte, value arbitrary
	localparam logic [7:0] SIG_VALUE = 8'h5a;

	// ----------------------------------------
	// Port 3 mode field
	// ----------------------------------------
	localparam int unsigned P3_MODE_LO = 1;
	localparam int unsigned P3_MODE_HI = 3;
	localparam int unsigned P3_SEL_BIT = 4;
	localparam logic [2:0] PM_ERASE = 3'h0;
	localparam logic [2:0] PM_SIG = 3'h1;
	localparam logic [2:0] PM_PROG = 3'h2;
	localparam logic [2:0] PM_READ = 3'h3;
	localparam logic [2:0] PM_SEC_PROG = 3'h4;
	localparam logic [2:0] PM_SEC_READ = 3'h5;
	localparam int unsigned SEC_W = 3;

	// ----------------------------------------
	// Data flash peripheral registers
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'hb9;
	localparam logic [7:0] REG_DATA1 = 8'hbc;
	localparam logic [7:0] REG_DATA4 = 8'hbf;
	localparam logic [7:0] REG_PAGE = 8'hc6;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CMD_READ = 8'h01;
	localparam logic [7:0] CMD_PROG = 8'h02;
	localparam logic [7:0] CMD_VERIFY = 8'h04;
	localparam logic [7:0] CMD_ERASE = 8'h05;
	localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
	localparam logic [7:0] VERIFY_BAD = 8'h01;

	typedef struct packed {
		logic safe;
		logic secure;
		logic lock;
	} pfps_sec_s;

	typedef struct packed {
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] p3;
		logic ale;
	} pfps_par_s;

	function automatic logic pfps_erased(input logic [7:0] v);
		return v == ERASED;
	endfunction
endpackage
